// ==== rtl/tpop_trace_path.v ====
/*
 * Trace packet output path: watch unit, software trace source with its
 * arbiter and timestamps, packet buffer, formatter and trace-out stage.
 * Assumes all control inputs come from logic on the core clock; only the
 * trace-out clock arrives from outside and is sampled.
 */
// Summary of operation
// - Packets are buffered, optionally formatted, then serialized onto trace pins.
// - Only packets from the on-chip sources reach the trace pins.
// - The buffer decouples the source rate from the trace-out rate.
// - With formatting on, each word is preceded by a source identifier byte.
// - Outputs are serial trace, trace port clock and four trace lanes.
// - The shared pad carries serial trace or lane 0, never both.
// - Serial trace is driven identically on two pads.
// - All trace leaves the source as packets sent to the buffer.
// - Arbitration grants software first, hardware second, timestamps last.
// - A stimulus write produces one software packet.
// - A 21-bit counter gives timestamps relative to emitted packets.
// - A watch event yields a hardware packet or a halt request.
// - Each comparator uses its own compare, mask and function settings.
// - A watchpoint match requests a halt into debug state.
// - Periodic and cycle-match PC sampling, plus instruction cycle counting.
// - Exception entry, exit and return each emit a packet when enabled.
`include "tpop_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module tpop_trace_path (
    // Clock and reset
    input wire core_clk_in,
    input wire resetn_in,
    // Configuration
    input wire parallel_mode_in,
    input wire formatter_en_in,
    input wire timestamp_en_in,
    input wire exc_trace_en_in,
    input wire pc_sample_en_in,
    input wire cycle_count_en_in,
    // Stimulus writes
    input wire stim_wr_in,
    input wire [4:0] stim_port_in,
    input wire [23:0] stim_data_in,
    output wire stim_ready_out,
    // Core observation
    input wire access_valid_in,
    input wire [31:0] access_addr_in,
    input wire [31:0] pc_in,
    input wire exc_event_in,
    input wire [1:0] exc_kind_in,
    input wire [8:0] exc_num_in,
    // Comparator settings
    input wire [63:0] cmp_value_in,
    input wire [9:0] cmp_mask_in,
    input wire [7:0] cmp_func_in,
    // Status
    output reg halt_req_out,
    output reg hw_drop_out,
    output reg [31:0] cycle_count_out,
    output wire trace_busy_out,
    // Trace link
    input wire trace_out_clk_in,
    output reg shared_pad_out,
    output reg swo_mirror_out,
    output reg trace_port_clock_out,
    output reg trace_lane_1_out,
    output reg trace_lane_2_out,
    output reg trace_lane_3_out,
    output reg parallel_sel_out
);

localparam ST_IDLE = 2'b01;
localparam ST_SEND = 2'b10;

function cmp_hit;
    input [31:0] a;
    input [31:0] v;
    input [4:0] m;
    begin
        cmp_hit = (((a ^ v) & ~((32'h00000001 << m) - 32'h00000001)) == 32'h00000000);
    end
endfunction

wire [1:0] addr_hit;
wire [1:0] wp_hit;
wire [1:0] dt_hit;
wire [1:0] cc_hit;
wire pc_event;
wire exc_ev;
wire hw_new;
reg [31:0] next_hw_word;
reg hw_pend;
reg [31:0] hw_word;
reg sw_pend;
reg [31:0] sw_word;
reg ts_pend;
reg [31:0] ts_word;
reg [`TPOP_TS_W-1:0] ts_cnt;
wire sw_grant;
wire hw_grant;
wire ts_grant;
wire buf_in_ready;
reg buf_in_valid;
reg [31:0] buf_in_data;
wire buf_out_valid;
wire buf_out_ready;
wire [31:0] buf_out_data;
wire link_clk_s;
reg link_clk_d;
wire link_edge;
reg [1:0] state;
reg [31:0] word;
reg fmt_q;
reg [2:0] byte_idx;
reg [3:0] unit_cnt;
reg [7:0] cur_byte;
wire [2:0] last_byte;
wire [3:0] last_unit;
reg ser_bit;

// Cycle counter and periodic sampling
always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        cycle_count_out <= 32'h00000000;
    end else if (cycle_count_en_in) begin
        cycle_count_out <= cycle_count_out + 32'h00000001;
    end
end

genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
        wire [3:0] func = cmp_func_in[4*gi+3:4*gi];
        wire [4:0] mbits = cmp_mask_in[5*gi+4:5*gi];
        wire [31:0] val = cmp_value_in[32*gi+31:32*gi];
        assign addr_hit[gi] = access_valid_in && cmp_hit(access_addr_in, val, mbits);
        assign wp_hit[gi] = addr_hit[gi] && (func == `TPOP_FUNC_WATCH);
        assign dt_hit[gi] = addr_hit[gi] && (func == `TPOP_FUNC_DTRACE);
        assign cc_hit[gi] = cycle_count_en_in && (func == `TPOP_FUNC_PCSMP) &&
            cmp_hit(cycle_count_out, val, mbits);
    end
endgenerate

assign pc_event = |cc_hit || (pc_sample_en_in && cycle_count_en_in &&
    ((cycle_count_out & `TPOP_PC_PERIOD_MASK) == 32'h00000000));
assign exc_ev = exc_trace_en_in && exc_event_in && (exc_kind_in != 2'h0);
assign hw_new = exc_ev || (|dt_hit) || pc_event;

// Hardware packet contents, exception first
always @* begin
    if (exc_ev) begin
        next_hw_word = {`TPOP_HWID_EXC, `TPOP_HW_TAG, 13'h0000, exc_kind_in, exc_num_in};
    end else if (|dt_hit) begin
        next_hw_word = {`TPOP_HWID_DT, `TPOP_HW_TAG, access_addr_in[23:0]};
    end else begin
        next_hw_word = {`TPOP_HWID_PC, `TPOP_HW_TAG, pc_in[23:0]};
    end
end

// Watch events: halt request or hardware packet
always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        halt_req_out <= 1'b0;
        hw_drop_out <= 1'b0;
        hw_pend <= 1'b0;
        hw_word <= 32'h00000000;
    end else begin
        halt_req_out <= |wp_hit;
        hw_drop_out <= hw_new && hw_pend && !hw_grant;
        if (hw_new && (!hw_pend || hw_grant)) begin
            hw_pend <= 1'b1;
            hw_word <= next_hw_word;
        end else if (hw_grant) begin
            hw_pend <= 1'b0;
        end
    end
end

// Stimulus writes held until granted
assign stim_ready_out = !sw_pend;
always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        sw_pend <= 1'b0;
        sw_word <= 32'h00000000;
    end else if (stim_wr_in && !sw_pend) begin
        sw_pend <= 1'b1;
        sw_word <= {stim_port_in, `TPOP_SW_TAG, stim_data_in};
    end else if (sw_grant) begin
        sw_pend <= 1'b0;
    end
end

// Timestamp counter, captured after each data packet
always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        ts_cnt <= {`TPOP_TS_W{1'b0}};
        ts_pend <= 1'b0;
        ts_word <= 32'h00000000;
    end else begin
        if (sw_grant || hw_grant) begin
            ts_cnt <= {`TPOP_TS_W{1'b0}};
            ts_word <= {`TPOP_TS_HDR, 3'h0, ts_cnt};
        end else if (ts_cnt != {`TPOP_TS_W{1'b1}}) begin
            ts_cnt <= ts_cnt + 21'h000001;
        end
        if ((sw_grant || hw_grant) && timestamp_en_in) begin
            ts_pend <= 1'b1;
        end else if (ts_grant) begin
            ts_pend <= 1'b0;
        end
    end
end

// Fixed priority arbiter into the buffer
assign sw_grant = sw_pend && buf_in_ready;
assign hw_grant = hw_pend && buf_in_ready && !sw_pend;
assign ts_grant = ts_pend && buf_in_ready && !sw_pend && !hw_pend;

always @* begin
    buf_in_valid = sw_pend || hw_pend || ts_pend;
    if (sw_pend) begin
        buf_in_data = sw_word;
    end else if (hw_pend) begin
        buf_in_data = hw_word;
    end else begin
        buf_in_data = ts_word;
    end
end

tpop_buf2 #(
    .WIDTH(`TPOP_PKT_W)
) u_buf (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(buf_in_valid),
    .in_ready_out(buf_in_ready),
    .in_data_in(buf_in_data),
    .out_valid_out(buf_out_valid),
    .out_ready_in(buf_out_ready),
    .out_data_out(buf_out_data)
);

// Trace-out clock sampling
tpop_sync u_link_sync (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .async_in(trace_out_clk_in),
    .sync_out(link_clk_s)
);

always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        link_clk_d <= 1'b0;
    end else begin
        link_clk_d <= link_clk_s;
    end
end

assign link_edge = link_clk_s && !link_clk_d;
assign buf_out_ready = (state == ST_IDLE);
assign trace_busy_out = (state == ST_SEND) || buf_out_valid;
assign last_byte = fmt_q ? `TPOP_LAST_BYTE_FMT : `TPOP_LAST_BYTE;
assign last_unit = parallel_sel_out ? (`TPOP_PAR_UNITS - 4'h1) : (`TPOP_SER_UNITS - 4'h1);

// Formatter: byte order of one word
always @* begin
    case (fmt_q ? byte_idx : byte_idx + 3'h1)
        3'h0: cur_byte = {`TPOP_FMT_ID, 1'b1};
        3'h1: cur_byte = word[31:24];
        3'h2: cur_byte = word[7:0];
        3'h3: cur_byte = word[15:8];
        3'h4: cur_byte = word[23:16];
        default: cur_byte = 8'h00;
    endcase
end

// Serial frame: start bit, eight data bits LSB first, stop bit
always @* begin
    if (unit_cnt == 4'h0) begin
        ser_bit = 1'b0;
    end else if (unit_cnt == `TPOP_SER_UNITS - 4'h1) begin
        ser_bit = 1'b1;
    end else begin
        ser_bit = cur_byte[unit_cnt[2:0] - 3'h1];
    end
end

// Trace-out stage
always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        state <= ST_IDLE;
        word <= 32'h00000000;
        fmt_q <= 1'b0;
        byte_idx <= 3'h0;
        unit_cnt <= 4'h0;
        parallel_sel_out <= 1'b0;
        shared_pad_out <= 1'b1;
        swo_mirror_out <= 1'b1;
        trace_port_clock_out <= 1'b0;
        trace_lane_1_out <= 1'b0;
        trace_lane_2_out <= 1'b0;
        trace_lane_3_out <= 1'b0;
    end else begin
        case (state)
            ST_IDLE: begin
                parallel_sel_out <= parallel_mode_in;
                if (!parallel_mode_in) begin
                    shared_pad_out <= 1'b1;
                end
                swo_mirror_out <= 1'b1;
                if (buf_out_valid) begin
                    state <= ST_SEND;
                    word <= buf_out_data;
                    fmt_q <= formatter_en_in;
                    byte_idx <= 3'h0;
                    unit_cnt <= 4'h0;
                end
            end
            ST_SEND: begin
                if (link_edge) begin
                    if (parallel_sel_out) begin
                        shared_pad_out <= unit_cnt[0] ? cur_byte[4] : cur_byte[0];
                        trace_lane_1_out <= unit_cnt[0] ? cur_byte[5] : cur_byte[1];
                        trace_lane_2_out <= unit_cnt[0] ? cur_byte[6] : cur_byte[2];
                        trace_lane_3_out <= unit_cnt[0] ? cur_byte[7] : cur_byte[3];
                        trace_port_clock_out <= ~trace_port_clock_out;
                    end else begin
                        shared_pad_out <= ser_bit;
                        swo_mirror_out <= ser_bit;
                    end
                    if (unit_cnt == last_unit) begin
                        unit_cnt <= 4'h0;
                        if (byte_idx == last_byte) begin
                            state <= ST_IDLE;
                        end else begin
                            byte_idx <= byte_idx + 3'h1;
                        end
                    end else begin
                        unit_cnt <= unit_cnt + 4'h1;
                    end
                end
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

endmodule // tpop_trace_path

`default_nettype wire

// ==== rtl/tpop_defines.vh ====
/*
 * Constants for the trace packet output path: packet layout, comparator
 * functions, hardware packet identifiers and serializer framing.
 * Assumes it is included by the design files of the trace path and by the testbench.
 */
`ifndef TPOP_DEFINES_VH
`define TPOP_DEFINES_VH

// Packet word: header byte in [31:24], payload in [23:0]
`define TPOP_PKT_W 32
`define TPOP_TS_W 21
// Header tags in the low three header bits; the timestamp header is a whole byte
`define TPOP_SW_TAG 3'h1
`define TPOP_HW_TAG 3'h5
`define TPOP_TS_HDR 8'hC0
// Hardware packet identifiers
`define TPOP_HWID_EXC 5'h01
`define TPOP_HWID_DT 5'h02
`define TPOP_HWID_PC 5'h03
// Formatter source identifier, arbitrary value
`define TPOP_FMT_ID 7'h01
// Comparator function codes
`define TPOP_FUNC_PCSMP 4'h1
`define TPOP_FUNC_DTRACE 4'h2
`define TPOP_FUNC_WATCH 4'h3
// Periodic program-counter sample interval mask on the cycle counter
`define TPOP_PC_PERIOD_MASK 32'h000003FF
// Serializer units per byte and index of the last byte of a word
`define TPOP_SER_UNITS 4'hA
`define TPOP_PAR_UNITS 4'h2
`define TPOP_LAST_BYTE 3'h3
`define TPOP_LAST_BYTE_FMT 3'h4

`endif

// ==== rtl/tpop_sync.v ====
/*
 * Two-flop synchronizer for one level from outside the core clock domain.
 * Assumes the input is slow against the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tpop_sync (
    // Clock and reset
    input wire core_clk_in,
    input wire resetn_in,
    // Level
    input wire async_in,
    output wire sync_out
);

reg stage1;
reg stage2;

always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        stage1 <= 1'b0;
        stage2 <= 1'b0;
    end else begin
        stage1 <= async_in;
        stage2 <= stage1;
    end
end

assign sync_out = stage2;

endmodule // tpop_sync

`default_nettype wire

// ==== rtl/tpop_buf2.v ====
/*
 * Two-entry packet buffer with valid and ready on both sides.
 * Assumes both sides run on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tpop_buf2 #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input wire core_clk_in,
    input wire resetn_in,
    // Fill side
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    // Drain side
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);

reg [WIDTH-1:0] mem [0:1];
reg wr_ptr;
reg rd_ptr;
reg [1:0] count;
wire push;
wire pop;

assign in_ready_out = (count != 2'h2);
assign out_valid_out = (count != 2'h0);
assign out_data_out = mem[rd_ptr];
assign push = in_valid_in && in_ready_out;
assign pop = out_valid_out && out_ready_in;

always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        mem[0] <= {WIDTH{1'b0}};
        mem[1] <= {WIDTH{1'b0}};
        wr_ptr <= 1'b0;
        rd_ptr <= 1'b0;
        count <= 2'h0;
    end else begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
            wr_ptr <= ~wr_ptr;
        end
        if (pop) begin
            rd_ptr <= ~rd_ptr;
        end
        if (push && !pop) begin
            count <= count + 2'h1;
        end else if (pop && !push) begin
            count <= count - 2'h1;
        end
    end
end

endmodule // tpop_buf2

`default_nettype wire

// ==== bench/tpop_trace_checker.sv ====
/* Concurrent checks on the ports of the trace packet output path.
   Assumes it is bound to tpop_trace_path, all in the core clock domain. */
`timescale 1ns/1ps
`default_nettype none
module tpop_trace_checker (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Inputs watched
    input wire logic stim_wr_in,
    input wire logic access_valid_in,
    input wire logic [31:0] access_addr_in,
    input wire logic [63:0] cmp_value_in,
    input wire logic [9:0] cmp_mask_in,
    input wire logic [7:0] cmp_func_in,
    input wire logic cycle_count_en_in,
    input wire logic trace_out_clk_in,
    // Outputs watched
    input wire logic stim_ready_out,
    input wire logic halt_req_out,
    input wire logic [31:0] cycle_count_out,
    input wire logic shared_pad_out,
    input wire logic swo_mirror_out,
    input wire logic trace_port_clock_out,
    input wire logic trace_lane_1_out,
    input wire logic parallel_sel_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    // Accepted stimulus write
    sequence stim_take;
        stim_wr_in && stim_ready_out;
    endsequence
    // Watchpoint hit on comparator 0
    sequence wp_hit;
        access_valid_in && cmp_func_in[3:0] == 4'h3 &&
            ((access_addr_in ^ cmp_value_in[31:0]) >> cmp_mask_in[4:0]) == 32'h0;
    endsequence
    pad_mirror_a: assert property (
        !parallel_sel_out |-> shared_pad_out == swo_mirror_out) else $error("pads differ");
    pad_exclusive_a: assert property (
        parallel_sel_out |-> swo_mirror_out) else $error("serial active in parallel");
    stim_accept_a: assert property (
        stim_take |=> !stim_ready_out ##[1:1000] stim_ready_out) else $error("stim ready");
    halt_set_a: assert property (
        wp_hit |=> halt_req_out) else $error("no halt on match");
    halt_cause_a: assert property (
        halt_req_out |-> $past(access_valid_in)) else $error("halt without access");
    cycle_step_a: assert property (
        cycle_count_en_in |=> cycle_count_out == $past(cycle_count_out) + 32'h1)
        else $error("cycle count step");
    cycle_hold_a: assert property (
        !cycle_count_en_in |=> $stable(cycle_count_out)) else $error("cycle count moved");
    link_edge_a: assert property (
        $changed(trace_port_clock_out) |-> $past(trace_out_clk_in, 1) &&
            $past(trace_out_clk_in, 2)) else $error("clock off link edge");
    lane_clock_a: assert property (
        parallel_sel_out && $changed(trace_lane_1_out) |-> $changed(trace_port_clock_out))
        else $error("lane change without clock");
endmodule // tpop_trace_checker
bind tpop_trace_path tpop_trace_checker chk_u (.core_clk_in, .resetn_in, .stim_wr_in,
    .access_valid_in, .access_addr_in, .cmp_value_in, .cmp_mask_in, .cmp_func_in,
    .cycle_count_en_in, .trace_out_clk_in, .stim_ready_out, .halt_req_out, .cycle_count_out,
    .shared_pad_out, .swo_mirror_out, .trace_port_clock_out, .trace_lane_1_out,
    .parallel_sel_out);
`default_nettype wire

// ==== bench/tpop_probe.sv ====
/* Trace capture probe: decodes serial frames or parallel nibbles into bytes.
   Assumes pins settle well before the falling edge of the trace-out clock. */
`timescale 1ns/1ps
`default_nettype none
module tpop_probe (
    // Trace-out clock
    input wire logic trace_out_clk_in,
    // Trace pins
    input wire logic parallel_sel_in,
    input wire logic shared_pad_in,
    input wire logic trace_port_clock_in,
    input wire logic [2:0] lanes_in,
    // Decoded bytes
    output var logic [7:0] rx_byte_out,
    output var logic rx_toggle_out
);
    logic [7:0] shift = 8'h00;
    logic [3:0] cnt = 4'h0;
    logic last_clk = 1'b0;
    initial rx_toggle_out = 1'b0;
    task automatic emit();
        rx_byte_out = shift;
        rx_toggle_out = ~rx_toggle_out;
        cnt = 4'h0;
    endtask
    // Pins are read mid-bit, away from their change point
    always @(negedge trace_out_clk_in) begin
        if (parallel_sel_in) begin
            if (trace_port_clock_in != last_clk) begin
                shift = {lanes_in, shared_pad_in, shift[7:4]};
                cnt = cnt + 4'h1;
                if (cnt == 4'h2) emit();
            end
        end else if (cnt == 4'h0) begin
            if (!shared_pad_in) cnt = 4'h1;
        end else if (cnt < 4'h9) begin
            shift = {shared_pad_in, shift[7:1]};
            cnt = cnt + 4'h1;
        end else begin
            cnt = 4'h0;
            if (shared_pad_in) emit();
        end
        last_clk = trace_port_clock_in;
    end
endmodule // tpop_probe
`default_nettype wire

// ==== bench/testbench.sv ====
/* Self-checking bench for the trace packet output path with a capture probe.
   Assumes the design, checker and probe files are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "tpop_defines.vh"
module testbench;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic trace_out_clk_in = 1'b0;
    logic parallel_mode_in = 1'b0;
    logic formatter_en_in = 1'b0;
    logic timestamp_en_in = 1'b0;
    logic exc_trace_en_in = 1'b1;
    logic cycle_count_en_in = 1'b1;
    logic [31:0] pc_in = 32'h00000000;
    logic [7:0] cc_mark;
    logic stim_wr_in = 1'b0;
    logic [4:0] stim_port_in = 5'h00;
    logic [23:0] stim_data_in = 24'h000000;
    logic access_valid_in = 1'b0;
    logic [31:0] access_addr_in = 32'h00000000;
    logic exc_event_in = 1'b0;
    logic [1:0] exc_kind_in = 2'h0;
    logic [8:0] exc_num_in = 9'h000;
    logic [63:0] cmp_value_in = 64'h0;
    logic [9:0] cmp_mask_in = 10'h000;
    logic [7:0] cmp_func_in = 8'h00;
    wire stim_ready_out, halt_req_out, trace_busy_out, shared_pad_out, swo_mirror_out;
    wire trace_port_clock_out, trace_lane_1_out, trace_lane_2_out, trace_lane_3_out;
    wire parallel_sel_out, rx_toggle, hw_drop_out;
    wire [31:0] cycle_count_out;
    wire [7:0] rx_byte;
    logic [15:0] expq[$];
    logic [15:0] e;
    logic [31:0] seed = 32'h86629B45;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    always #2.5 core_clk_in = ~core_clk_in;
    always #32 trace_out_clk_in = ~trace_out_clk_in;
    tpop_trace_path dut_u (.core_clk_in, .resetn_in, .parallel_mode_in, .formatter_en_in,
        .timestamp_en_in, .exc_trace_en_in, .pc_sample_en_in(1'b0),
        .cycle_count_en_in, .stim_wr_in, .stim_port_in, .stim_data_in, .stim_ready_out,
        .access_valid_in, .access_addr_in, .pc_in, .exc_event_in, .exc_kind_in,
        .exc_num_in, .cmp_value_in, .cmp_mask_in, .cmp_func_in, .halt_req_out, .hw_drop_out,
        .cycle_count_out, .trace_busy_out, .trace_out_clk_in, .shared_pad_out,
        .swo_mirror_out, .trace_port_clock_out, .trace_lane_1_out, .trace_lane_2_out,
        .trace_lane_3_out, .parallel_sel_out);
    tpop_probe probe_u (.trace_out_clk_in, .parallel_sel_in(parallel_sel_out),
        .shared_pad_in(shared_pad_out), .trace_port_clock_in(trace_port_clock_out),
        .lanes_in({trace_lane_3_out, trace_lane_2_out, trace_lane_1_out}),
        .rx_byte_out(rx_byte), .rx_toggle_out(rx_toggle));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            miscompares++;
        end
    endtask
    task automatic finish_test();
        if (miscompares == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic expect_word(input logic [7:0] hdr, input logic [23:0] d);
        if (formatter_en_in) expq.push_back({8'hFF, `TPOP_FMT_ID, 1'b1});
        expq.push_back({8'hFF, hdr});
        expq.push_back({8'hFF, d[7:0]});
        expq.push_back({8'hFF, d[15:8]});
        expq.push_back({8'hFF, d[23:16]});
    endtask
    task automatic stim(input logic [4:0] p, input logic [23:0] d);
        int n;
        n = 0;
        while (stim_ready_out !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        stim_wr_in = 1'b1;
        stim_port_in = p;
        stim_data_in = d;
        expect_word({p, `TPOP_SW_TAG}, d);
        tick(1);
        stim_wr_in = 1'b0;
    endtask
    task automatic rand_stim();
        repeat (8) seed = lfsr(seed);
        stim(seed[28:24], seed[23:0]);
    endtask
    task automatic drain();
        int n;
        n = 0;
        while ((expq.size() != 0 || trace_busy_out !== 1'b0) && n < 20000) begin
            tick(1);
            n++;
        end
        tick(40);
    endtask
    always @(rx_toggle) begin
        if (resetn_in === 1'b1) begin
            if (expq.size() == 0) check("spurious_byte", 8'h01, 8'h00);
            else begin
                e = expq.pop_front();
                check("trace_byte", rx_byte & e[15:8], e[7:0]);
            end
        end
    end
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        tick(5);
        check("reset_pins", {2'h0, hw_drop_out, shared_pad_out, swo_mirror_out, stim_ready_out,
            trace_busy_out, halt_req_out}, 8'h1C);
        check("reset_count", cycle_count_out[7:0], 8'h00);
        tick(1);
        resetn_in = 1'b1;
        tick(4);
        repeat (6) rand_stim();
        drain();
        formatter_en_in = 1'b1;
        repeat (2) rand_stim();
        drain();
        formatter_en_in = 1'b0;
        stim_port_in = 5'h1E;
        stim_data_in = 24'hA5C33C;
        for (int k = 0; k < 4; k++) begin
            exc_kind_in = k[1:0];
            exc_num_in = seed[8:0] ^ 9'(k);
            exc_event_in = 1'b1;
            if (k == 1) begin
                stim_wr_in = 1'b1;
                expect_word({5'h1E, `TPOP_SW_TAG}, 24'hA5C33C);
            end
            if (k != 0) expect_word({`TPOP_HWID_EXC, `TPOP_HW_TAG}, {13'h0, exc_kind_in,
                exc_num_in});
            tick(1);
            if (k == 1) begin
                stim_wr_in = 1'b0;
                tick(1);
                check("hw_drop", {7'h0, hw_drop_out}, 8'h01);
            end
            exc_event_in = 1'b0;
            stim_wr_in = 1'b0;
            drain();
        end
        exc_trace_en_in = 1'b0;
        exc_kind_in = 2'h1;
        exc_event_in = 1'b1;
        tick(1);
        exc_event_in = 1'b0;
        tick(3);
        check("exc_trace_off", {7'h0, trace_busy_out}, 8'h00);
        exc_trace_en_in = 1'b1;
        seed = lfsr(seed);
        cmp_value_in = {seed ^ 32'hFF000000, seed};
        cmp_mask_in = 10'h004;
        cmp_func_in = {`TPOP_FUNC_DTRACE, `TPOP_FUNC_WATCH};
        access_valid_in = 1'b1;
        access_addr_in = seed ^ 32'h0000000F;
        tick(1);
        check("halt_on_match", {7'h0, halt_req_out}, 8'h01);
        access_addr_in = seed ^ 32'hFF000000;
        expect_word({`TPOP_HWID_DT, `TPOP_HW_TAG}, access_addr_in[23:0]);
        tick(1);
        access_valid_in = 1'b0;
        check("halt_on_miss", {7'h0, halt_req_out}, 8'h00);
        drain();
        cmp_mask_in = 10'h000;
        cmp_func_in = {4'h0, `TPOP_FUNC_PCSMP};
        seed = lfsr(seed);
        pc_in = seed;
        cmp_value_in[31:0] = cycle_count_out + 32'h00000014;
        expect_word({`TPOP_HWID_PC, `TPOP_HW_TAG}, seed[23:0]);
        cc_mark = cycle_count_out[7:0];
        tick(10);
        check("cycle_count", cycle_count_out[7:0] - cc_mark, 8'h0A);
        drain();
        cycle_count_en_in = 1'b0;
        cc_mark = cycle_count_out[7:0];
        tick(5);
        check("cycle_hold", cycle_count_out[7:0], cc_mark);
        cycle_count_en_in = 1'b1;
        cmp_func_in = 8'h00;
        timestamp_en_in = 1'b1;
        rand_stim();
        expq.push_back({8'hFF, `TPOP_TS_HDR});
        expq.push_back(16'h0000);
        expq.push_back(16'h0000);
        expq.push_back(16'hE000);
        drain();
        timestamp_en_in = 1'b0;
        parallel_mode_in = 1'b1;
        tick(4);
        check("parallel_sel", {7'h0, parallel_sel_out}, 8'h01);
        repeat (3) rand_stim();
        drain();
        parallel_mode_in = 1'b0;
        tick(4);
        check("serial_idle", {6'h0, shared_pad_out, swo_mirror_out}, 8'h03);
        check("bytes_left", 8'(expq.size()), 8'h00);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
